// ===== giv_pkg.sv
// package for the guest intercept vector block: control-area map, field
// positions, event kinds and the carrier structs.
// assumes nothing of its surroundings; imported by giv_intercept_vectors.
`default_nettype none
package giv_pkg;
   // control area geometry: byte address, one 32-bit word per vector
   localparam int unsigned CTL_AREA_BYTES = 1024;
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned NUM_VEC = 6;
   localparam logic [ADDR_W-1:0] OFF_CR_TRAP = 10'h000;
   localparam logic [ADDR_W-1:0] OFF_DR_TRAP = 10'h004;
   localparam logic [ADDR_W-1:0] OFF_EXC_TRAP = 10'h008;
   localparam logic [ADDR_W-1:0] OFF_EVT_TRAP = 10'h00c;
   localparam logic [ADDR_W-1:0] OFF_INS2_TRAP = 10'h010;
   localparam logic [ADDR_W-1:0] OFF_INS3_TRAP = 10'h014;
   // reset value of every vector word
   localparam logic [31:0] VEC_RST = 32'h0000_0000;
   // implemented bits of the last vector word; the rest read zero
   localparam logic [31:0] INS3_IMPL_MASK = 32'h0000_0007;
   localparam logic [31:0] FULL_MASK = 32'hffff_ffff;
   // read and write halves of the control and debug register words
   localparam int unsigned RD_HALF_LSB = 0;
   localparam int unsigned WR_HALF_LSB = 16;
   // event vector word fields
   localparam int unsigned EVT_IRQ_LSB = 0;
   localparam int unsigned EVT_IRQ_CNT = 5;
   localparam int unsigned EVT_CR0_SEL = 5;
   localparam int unsigned EVT_TBL_RD_LSB = 6;
   localparam int unsigned EVT_TBL_WR_LSB = 10;
   localparam int unsigned EVT_TBL_CNT = 4;
   localparam int unsigned EVT_INSTR_LSB = 14;
   localparam int unsigned EVT_INSTR_CNT = 13;
   localparam int unsigned EVT_PORT = 27;
   localparam int unsigned EVT_MSR = 28;
   localparam int unsigned EVT_TASK = 29;
   localparam int unsigned EVT_FERR = 30;
   localparam int unsigned EVT_SHUT = 31;
   // second instruction word fields
   localparam int unsigned INS2_CNT = 15;
   localparam int unsigned INS2_WAIT = 11;
   localparam int unsigned INS2_WAIT_ARMED = 12;
   localparam int unsigned INS2_EXTENDED_FEATURE_ENABLE_REG_WR = 15;
   localparam int unsigned INS2_CR_WR_LSB = 16;
   // third instruction word fields
   localparam int unsigned INS3_BCAST_ALL = 0;
   localparam int unsigned INS3_BCAST_BAD = 1;
   localparam int unsigned INS3_PROCESS_CONTEXT_INVALIDATE = 2;

   // candidate guest event classes
   typedef enum logic [4:0] {
      GIV_K_NONE = 5'b00000,
      GIV_K_CR_RD = 5'b00001,
      GIV_K_CR_WR = 5'b00010,
      GIV_K_DR_RD = 5'b00011,
      GIV_K_DR_WR = 5'b00100,
      GIV_K_EXC = 5'b00101,
      GIV_K_IRQ = 5'b00110,
      GIV_K_TBL_RD = 5'b00111,
      GIV_K_TBL_WR = 5'b01000,
      GIV_K_INSTR = 5'b01001,
      GIV_K_PORT = 5'b01010,
      GIV_K_MSR = 5'b01011,
      GIV_K_TASK = 5'b01100,
      GIV_K_FERR = 5'b01101,
      GIV_K_SHUT = 5'b01110,
      GIV_K_INSTR2 = 5'b01111,
      GIV_K_EXTENDED_FEATURE_ENABLE_REG_WR = 5'b10000,
      GIV_K_BCAST = 5'b10001,
      GIV_K_PROCESS_CONTEXT_INVALIDATE = 5'b10010
   } giv_kind_t;

   // one candidate event offered by the core
   typedef struct packed {
      logic valid;
      giv_kind_t kind;
      logic [4:0] index;
      logic cr0_other_chg;
      logic mon_armed;
      logic bad_spec;
      logic map_hit;
   } giv_event_t;

   // decision returned one cycle later
   typedef struct packed {
      logic valid;
      logic exit_now;
      logic exit_after;
      giv_kind_t kind;
      logic [4:0] index;
   } giv_verdict_t;
endpackage
`default_nettype wire

// ===== giv_intercept_vectors.sv
// intercept decision block: holds the intercept vectors of the guest
// control block control area and judges each candidate guest event.
// assumes a single core clock, a one-cycle register strobe port and one
// candidate event per cycle; the permission maps are consulted elsewhere
// and arrive here as a single hit bit.
`timescale 1ns/100ps
`default_nettype none
module giv_intercept_vectors (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic [giv_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire giv_pkg::giv_event_t i_event,
   output giv_pkg::giv_verdict_t o_verdict
);
   import giv_pkg::*;

   // registers served by each half of the control and debug vector words
   localparam int unsigned NUM_HALF_REGS = WR_HALF_LSB - RD_HALF_LSB;

   // the decoder and the array both assume exactly this geometry
   initial begin
      if (CTL_AREA_BYTES != (1 << ADDR_W) || NUM_VEC * 4 > CTL_AREA_BYTES) begin
         $error("control area geometry not supported");
      end
   end

   // pick one bit of a vector word; positions past bit 31 never trap
   function automatic logic bit_at(input logic [31:0] vec, input int unsigned pos);
      logic r;
      r = 1'b0;
      if (pos < 32) begin
         r = vec[pos[4:0]];
      end
      return r;
   endfunction

   // word index of a byte address; unaligned low bits are ignored
   function automatic int unsigned word_of(input logic [ADDR_W-1:0] a);
      int unsigned w;
      w = 32'(a[ADDR_W-1:2]);
      return w;
   endfunction

   // writable bits of each vector word
   function automatic logic [31:0] impl_mask(input int unsigned w);
      logic [31:0] m;
      m = FULL_MASK;
      if (w == word_of(OFF_INS3_TRAP)) begin
         m = INS3_IMPL_MASK;
      end
      return m;
   endfunction

   logic [31:0] vec_q [NUM_VEC];
   logic [31:0] rdata_d;
   logic exit_now_d;
   logic exit_after_d;
   int unsigned wsel;
   int unsigned idx;

   assign wsel = word_of(i_addr);
   assign idx = 32'(i_event.index);

   // vector words: plain storage, only implemented bits are kept
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         for (int i = 0; i < NUM_VEC; i++) begin
            vec_q[i] <= VEC_RST;
         end
      end else if (i_wr && wsel < NUM_VEC) begin
         vec_q[wsel] <= i_wdata & impl_mask(wsel);
      end
   end

   // read mux; padding past the vectors reads zero and ignores writes
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (wsel < NUM_VEC) begin
         rdata_d = vec_q[wsel];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         o_rdata <= rdata_d;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // intercept decision for the offered event
   always_comb begin
      exit_now_d = 1'b0;
      exit_after_d = 1'b0;
      case (i_event.kind)
         GIV_K_CR_RD: begin
            if (idx < NUM_HALF_REGS) begin
               exit_now_d = bit_at(vec_q[0], RD_HALF_LSB + idx);
            end
         end
         GIV_K_CR_WR: begin
            // a selective register-zero trap only fires on real mode changes
            exit_now_d = bit_at(vec_q[0], WR_HALF_LSB + idx)
               | (idx == 0 && vec_q[3][EVT_CR0_SEL] && i_event.cr0_other_chg);
            // a trap taken before the write leaves no write to report after it
            exit_after_d = !exit_now_d && bit_at(vec_q[4], INS2_CR_WR_LSB + idx);
         end
         GIV_K_DR_RD: begin
            if (idx < NUM_HALF_REGS) begin
               exit_now_d = bit_at(vec_q[1], RD_HALF_LSB + idx);
            end
         end
         GIV_K_DR_WR: begin
            exit_now_d = bit_at(vec_q[1], WR_HALF_LSB + idx);
         end
         GIV_K_EXC: begin
            exit_now_d = bit_at(vec_q[2], idx);
         end
         GIV_K_IRQ: begin
            if (idx < EVT_IRQ_CNT) begin
               exit_now_d = bit_at(vec_q[3], EVT_IRQ_LSB + idx);
            end
         end
         GIV_K_TBL_RD: begin
            if (idx < EVT_TBL_CNT) begin
               exit_now_d = bit_at(vec_q[3], EVT_TBL_RD_LSB + idx);
            end
         end
         GIV_K_TBL_WR: begin
            if (idx < EVT_TBL_CNT) begin
               exit_now_d = bit_at(vec_q[3], EVT_TBL_WR_LSB + idx);
            end
         end
         GIV_K_INSTR: begin
            if (idx < EVT_INSTR_CNT) begin
               exit_now_d = bit_at(vec_q[3], EVT_INSTR_LSB + idx);
            end
         end
         GIV_K_PORT: begin
            // the map lookup happens upstream; only marked ports reach a trap
            exit_now_d = vec_q[3][EVT_PORT] && i_event.map_hit;
         end
         GIV_K_MSR: begin
            exit_now_d = vec_q[3][EVT_MSR] && i_event.map_hit;
         end
         GIV_K_TASK: begin
            exit_now_d = vec_q[3][EVT_TASK];
         end
         GIV_K_FERR: begin
            exit_now_d = vec_q[3][EVT_FERR];
         end
         GIV_K_SHUT: begin
            exit_now_d = vec_q[3][EVT_SHUT];
         end
         GIV_K_INSTR2: begin
            if (idx == INS2_WAIT) begin
               // the armed-only bit widens the unconditional one, never narrows it
               exit_now_d = vec_q[4][INS2_WAIT]
                  | (vec_q[4][INS2_WAIT_ARMED] && i_event.mon_armed);
            end else if (idx < INS2_CNT && idx != INS2_WAIT_ARMED) begin
               exit_now_d = bit_at(vec_q[4], idx);
            end
         end
         GIV_K_EXTENDED_FEATURE_ENABLE_REG_WR: begin
            exit_after_d = vec_q[4][INS2_EXTENDED_FEATURE_ENABLE_REG_WR];
         end
         GIV_K_BCAST: begin
            exit_now_d = vec_q[5][INS3_BCAST_ALL]
               | (vec_q[5][INS3_BCAST_BAD] && i_event.bad_spec);
         end
         GIV_K_PROCESS_CONTEXT_INVALIDATE: begin
            exit_now_d = vec_q[5][INS3_PROCESS_CONTEXT_INVALIDATE];
         end
         default: begin
            exit_now_d = 1'b0;
            exit_after_d = 1'b0;
         end
      endcase
      if (!i_event.valid) begin
         exit_now_d = 1'b0;
         exit_after_d = 1'b0;
      end
   end

   // verdict register: one answer per offered event, one cycle later
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         o_verdict <= '0;
      end else begin
         o_verdict.valid <= i_event.valid;
         o_verdict.exit_now <= exit_now_d;
         o_verdict.exit_after <= exit_after_d;
         o_verdict.kind <= i_event.valid ? i_event.kind : GIV_K_NONE;
         o_verdict.index <= i_event.valid ? i_event.index : 5'h00;
      end
   end

   // helper terms read only by the checks below
   logic exc_sel;
   logic cr_wr_sel;
   assign exc_sel = vec_q[2][i_event.index];
   assign cr_wr_sel = vec_q[0][WR_HALF_LSB + 32'(i_event.index[3:0])];
   logic cr_rd_sel;
   logic dr_rd_sel;
   logic dr_wr_sel;
   assign cr_rd_sel = !i_event.index[4] && vec_q[0][RD_HALF_LSB + 32'(i_event.index[3:0])];
   assign dr_rd_sel = !i_event.index[4] && vec_q[1][RD_HALF_LSB + 32'(i_event.index[3:0])];
   assign dr_wr_sel = !i_event.index[4] && vec_q[1][WR_HALF_LSB + 32'(i_event.index[3:0])];

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   exc_trap_a: assert property (
      i_event.valid && i_event.kind == GIV_K_EXC
      |=> o_verdict.valid && o_verdict.exit_now == $past(exc_sel))
      else $error("exception trap verdict does not follow its vector bit");

   evt_word_wr_a: assert property (
      i_wr && i_addr == OFF_EVT_TRAP |=> vec_q[3] == $past(i_wdata))
      else $error("event vector word did not take the written value");

   pad_read_zero_a: assert property (
      i_rd && i_addr[ADDR_W-1:2] >= 8'(NUM_VEC) |=> o_rdata == 32'h0000_0000)
      else $error("unused control area word did not read zero");

   exc_read_a: assert property (
      i_rd && i_addr == OFF_EXC_TRAP |=> o_rdata == $past(vec_q[2])
      ##1 (o_rdata == 32'h0000_0000 || $past(i_rd)))
      else $error("read data wrong or held past its cycle");

   cr0_sel_a: assert property (
      i_event.valid && i_event.kind == GIV_K_CR_WR && i_event.index == 5'h00
      && vec_q[3][EVT_CR0_SEL] && i_event.cr0_other_chg |=> o_verdict.exit_now)
      else $error("selective register-zero write was not trapped");

   cr_late_a: assert property (
      i_event.valid && i_event.kind == GIV_K_CR_WR && !i_event.index[4] && cr_wr_sel
      |=> o_verdict.exit_now && !o_verdict.exit_after)
      else $error("early control register trap did not suppress late one");

   extended_feature_enable_reg_late_a: assert property (
      i_event.valid && i_event.kind == GIV_K_EXTENDED_FEATURE_ENABLE_REG_WR
      |=> !o_verdict.exit_now && o_verdict.exit_after == $past(vec_q[4][INS2_EXTENDED_FEATURE_ENABLE_REG_WR]))
      else $error("feature register write trap not reported as late");

   wait_armed_a: assert property (
      i_event.valid && i_event.kind == GIV_K_INSTR2 && i_event.index == 5'd11
      && !vec_q[4][INS2_WAIT] |=> o_verdict.exit_now == $past(vec_q[4][INS2_WAIT_ARMED]
      && i_event.mon_armed))
      else $error("armed wait trap wrong");

   bcast_bad_a: assert property (
      i_event.valid && i_event.kind == GIV_K_BCAST && !i_event.bad_spec
      && !vec_q[5][INS3_BCAST_ALL] |=> !o_verdict.exit_now)
      else $error("valid broadcast invalidation trapped without the all bit");

   port_map_a: assert property (
      i_event.valid && i_event.kind == GIV_K_PORT |=>
      o_verdict.exit_now == $past(vec_q[3][EVT_PORT] && i_event.map_hit))
      else $error("port trap ignored enable or map hit");

   idle_quiet_a: assert property (
      !i_event.valid |=> !o_verdict.valid && !o_verdict.exit_now && !o_verdict.exit_after)
      else $error("verdict raised with no event offered");

   cr_read_a: assert property (
      i_event.valid && i_event.kind == GIV_K_CR_RD |=> o_verdict.exit_now == $past(cr_rd_sel))
      else $error("control register read trap does not follow its vector bit");

   cr_write_a: assert property (
      i_event.valid && i_event.kind == GIV_K_CR_WR && i_event.index != 5'h00
      |=> o_verdict.exit_now == $past(!i_event.index[4] && cr_wr_sel))
      else $error("control register write trap does not follow its vector bit");

   dr_read_a: assert property (
      i_event.valid && i_event.kind == GIV_K_DR_RD |=> o_verdict.exit_now == $past(dr_rd_sel))
      else $error("debug register read trap does not follow its vector bit");

   dr_write_a: assert property (
      i_event.valid && i_event.kind == GIV_K_DR_WR |=> o_verdict.exit_now == $past(dr_wr_sel))
      else $error("debug register write trap does not follow its vector bit");

   irq_trap_a: assert property (
      i_event.valid && i_event.kind == GIV_K_IRQ && 32'(i_event.index) < EVT_IRQ_CNT
      |=> o_verdict.exit_now == $past(vec_q[3][EVT_IRQ_LSB + 32'(i_event.index)]))
      else $error("interrupt trap does not follow its vector bit");

   irq_range_a: assert property (
      i_event.valid && i_event.kind == GIV_K_IRQ && 32'(i_event.index) >= EVT_IRQ_CNT
      |=> o_verdict.valid && !o_verdict.exit_now)
      else $error("interrupt index past the five sources trapped");

   tbl_read_a: assert property (
      i_event.valid && i_event.kind == GIV_K_TBL_RD && 32'(i_event.index) < EVT_TBL_CNT
      |=> o_verdict.exit_now == $past(vec_q[3][EVT_TBL_RD_LSB + 32'(i_event.index)]))
      else $error("table pointer read trap does not follow its vector bit");

   tbl_write_a: assert property (
      i_event.valid && i_event.kind == GIV_K_TBL_WR && 32'(i_event.index) < EVT_TBL_CNT
      |=> o_verdict.exit_now == $past(vec_q[3][EVT_TBL_WR_LSB + 32'(i_event.index)]))
      else $error("table pointer write trap does not follow its vector bit");

   instr_trap_a: assert property (
      i_event.valid && i_event.kind == GIV_K_INSTR && 32'(i_event.index) < EVT_INSTR_CNT
      |=> o_verdict.exit_now == $past(vec_q[3][EVT_INSTR_LSB + 32'(i_event.index)]))
      else $error("instruction trap does not follow its vector bit");

   msr_map_a: assert property (
      i_event.valid && i_event.kind == GIV_K_MSR |=>
      o_verdict.exit_now == $past(vec_q[3][EVT_MSR] && i_event.map_hit))
      else $error("model register trap ignored enable or map hit");

   ferr_trap_a: assert property (
      i_event.valid && i_event.kind == GIV_K_FERR |=>
      o_verdict.exit_now == $past(vec_q[3][EVT_FERR]))
      else $error("floating-point freeze trap does not follow its vector bit");

   task_trap_a: assert property (
      i_event.valid && i_event.kind == GIV_K_TASK |=>
      o_verdict.exit_now == $past(vec_q[3][EVT_TASK]))
      else $error("task switch trap does not follow its vector bit");

   shut_trap_a: assert property (
      i_event.valid && i_event.kind == GIV_K_SHUT |=>
      o_verdict.exit_now == $past(vec_q[3][EVT_SHUT]))
      else $error("shutdown trap does not follow its vector bit");

   ins2_trap_a: assert property (
      i_event.valid && i_event.kind == GIV_K_INSTR2 && 32'(i_event.index) < INS2_WAIT
      |=> o_verdict.exit_now == $past(vec_q[4][i_event.index]))
      else $error("second-word instruction trap does not follow its vector bit");

   wait_uncond_a: assert property (
      i_event.valid && i_event.kind == GIV_K_INSTR2 && 32'(i_event.index) == INS2_WAIT
      && vec_q[4][INS2_WAIT] |=> o_verdict.exit_now)
      else $error("unconditional wait trap not taken");
endmodule
`default_nettype wire

// ===== giv_intercept_vectors_tb_top.sv
// self-checking bench for the guest intercept vector block: random register
// traffic and candidate events each cycle, checked against a behavioural model.
// assumes the design answers reads and events exactly one cycle later.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
   $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module giv_intercept_vectors_tb_top;
   import giv_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [31:0] i_wdata = '0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   giv_event_t i_event = '0;
   giv_verdict_t o_verdict;
   int seed = 76812;
   int bad_count = 0;
   int n_tests = 0;
   int mw [NUM_VEC];
   logic [31:0] exp_rd;
   giv_verdict_t exp_v;
   bit armed = 1'b0;

   giv_intercept_vectors uut (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .i_wr(i_wr),
      .i_rd(i_rd),
      .o_rdata(o_rdata),
      .i_event(i_event),
      .o_verdict(o_verdict)
   );

   // 250 MHz core clock
   always #2 i_mclk = ~i_mclk;

   // reference decision, written from the bit tables with plain integers
   function automatic giv_verdict_t judge(giv_event_t e);
      giv_verdict_t v;
      int x;
      logic now;
      logic aft;
      v = '0;
      now = 1'b0;
      aft = 1'b0;
      x = e.index;
      if (!e.valid) return v;
      case (e.kind)
         GIV_K_CR_RD: now = x < 16 && mw[0][x];
         GIV_K_CR_WR: begin
            now = (x < 16 && mw[0][16+x]) || (x == 0 && mw[3][5] && e.cr0_other_chg);
            aft = !now && x < 16 && mw[4][16+x];
         end
         GIV_K_DR_RD: now = x < 16 && mw[1][x];
         GIV_K_DR_WR: now = x < 16 && mw[1][16+x];
         GIV_K_EXC: now = mw[2][x];
         GIV_K_IRQ: now = x < 5 && mw[3][x];
         GIV_K_TBL_RD: now = x < 4 && mw[3][6+x];
         GIV_K_TBL_WR: now = x < 4 && mw[3][10+x];
         GIV_K_INSTR: now = x < 13 && mw[3][14+x];
         GIV_K_PORT: now = mw[3][27] && e.map_hit;
         GIV_K_MSR: now = mw[3][28] && e.map_hit;
         GIV_K_TASK: now = mw[3][29];
         GIV_K_FERR: now = mw[3][30];
         GIV_K_SHUT: now = mw[3][31];
         GIV_K_INSTR2: begin
            if (x == 11) now = mw[4][11] || (mw[4][12] && e.mon_armed);
            else now = x < 15 && x != 12 && mw[4][x];
         end
         GIV_K_EXTENDED_FEATURE_ENABLE_REG_WR: aft = mw[4][15];
         GIV_K_BCAST: now = mw[5][0] || (mw[5][1] && e.bad_spec);
         GIV_K_PROCESS_CONTEXT_INVALIDATE: now = mw[5][2];
         default: now = 1'b0;
      endcase
      v.valid = 1'b1;
      v.exit_now = now;
      v.exit_after = aft;
      v.kind = e.kind;
      v.index = e.index;
      return v;
   endfunction

   // model state: expectations use the words as they stood before this edge's write
   always @(posedge i_mclk) begin
      int a;
      a = i_addr[ADDR_W-1:2];
      armed <= 1'b1;
      if (!i_rstn) begin
         for (int k = 0; k < NUM_VEC; k++) mw[k] = 0;
         exp_rd <= '0;
         exp_v <= '0;
      end else begin
         exp_v <= judge(i_event);
         exp_rd <= (i_rd && a < NUM_VEC) ? 32'(mw[a]) : 32'h0000_0000;
         if (i_wr && a < NUM_VEC) mw[a] = (a == 5) ? (i_wdata & INS3_IMPL_MASK) : i_wdata;
      end
   end

   // compare mid-cycle, once the edge's updates have landed
   always @(negedge i_mclk) begin
      if (armed) begin
         `CHK("o_rdata", exp_rd, o_rdata)
         `CHK("o_verdict", exp_v, o_verdict)
      end
   end

   // one cycle of random strobes and one random candidate event
   task automatic rand_cycle(input bit reg_on);
      int r;
      int a;
      logic [31:0] d;
      giv_event_t ev;
      r = $unsigned($random(seed)) % 5;
      i_wr <= reg_on && r == 0;
      i_rd <= reg_on && (r == 1 || r == 2);
      a = ($unsigned($random(seed)) % 8) * 4 + $unsigned($random(seed)) % 4;
      if (r == 2) a = $unsigned($random(seed)) % CTL_AREA_BYTES;
      i_addr <= ADDR_W'(a);
      // half the writes are sparse so both trap outcomes occur often
      d = ($random(seed) % 2) ? $random(seed) : ($random(seed) & $random(seed));
      // unused bytes of the control area are only ever written as zero
      if (a / 4 >= NUM_VEC) d = 32'h0000_0000;
      else if (a / 4 == 5) d = d & 32'h0000_00ff;
      i_wdata <= d;
      ev = '0;
      ev.valid = ($unsigned($random(seed)) % 4) != 0;
      ev.kind = giv_kind_t'($unsigned($random(seed)) % 19);
      ev.index = 5'($unsigned($random(seed)));
      ev.cr0_other_chg = 1'($random(seed));
      ev.mon_armed = 1'($random(seed));
      ev.bad_spec = 1'($random(seed));
      ev.map_hit = 1'($random(seed));
      i_event <= ev;
      @(posedge i_mclk);
   endtask

   // software zeroes a freshly allocated control block, one word per cycle
   task automatic zero_fill();
      for (int k = 0; k < CTL_AREA_BYTES / 4; k++) begin
         i_wr <= 1'b1;
         i_addr <= ADDR_W'(k * 4);
         i_wdata <= 32'h0000_0000;
         @(posedge i_mclk);
      end
      i_wr <= 1'b0;
   endtask

   // read one word per cycle, back to back, over the whole control area
   task automatic sweep_reads();
      for (int k = 0; k < CTL_AREA_BYTES / 4; k++) begin
         i_rd <= 1'b1;
         i_addr <= ADDR_W'(k * 4);
         @(posedge i_mclk);
      end
      i_rd <= 1'b0;
      @(posedge i_mclk);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // main sequence: reset, sweep, random traffic, mid-run reset, sweep, more traffic
   initial begin
      repeat (20) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      zero_fill();
      sweep_reads();
      repeat (3000) rand_cycle(1'b1);
      // second reset in mid-run must clear every word again
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      i_event <= '0;
      i_rstn <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_rstn <= 1'b1;
      @(posedge i_mclk);
      zero_fill();
      sweep_reads();
      repeat (3000) rand_cycle(1'b1);
      // events alone, words left as the traffic wrote them
      repeat (500) rand_cycle(1'b0);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      i_event <= '0;
      repeat (3) @(posedge i_mclk);
      wrap_up();
   end

   // watchdog sized well above the roughly 7600 cycles of the sequence
   initial begin
      #(4 * 20000);
      bad_count++;
      wrap_up();
   end
endmodule
`undef CHK
`default_nettype wire
